// ---- shared/cwake_params.svh ----
/*
  Constants for the dual channel mode and wake detect block.
  Assumes a 25 MHz system clock and already-quantised bus levels.
*/
// Notes on behaviour
// R1 - high mode pin means standby, low normal
// R2 - normal: transmit low drives bus dominant
// R3 - normal: receive mirrors comparator, 0.9V/0.5V thresholds
// R4 - standby: driver off, bus weakly grounded
// R5 - standby: low-power receiver and monitor active
// R6 - standby: receive high until wake recognised
// R7 - wake shown only on its own channel
// R8 - host watches falls, then drives mode low
// R9 - filtered level persists longer than filter time
// R10 - dominant, recessive, dominant, recessive in order
// R11 - recognised at second recessive; dominants then low
// R12 - wake shown as fall plus dominant low
// R13 - short levels never advance, long always
// R14 - pattern must finish within wake timeout
// R15 - timeout discards all progress
// R16 - standby thresholds 1.15V and 0.4V
// R17 - dominant is logic low, recessive high
// R18 - floating mode pin reads as standby
// R19 - channels fully independent
// R20 - filter and timeout are cycle counters
`ifndef CWAKE_PARAMS_SVH
`define CWAKE_PARAMS_SVH
`define CWAKE_CLK_HZ          25000000
`define CWAKE_FILTER_NS       1000
`define CWAKE_FILTER_CYC      ((`CWAKE_FILTER_NS * 25 + 999) / 1000)
`define CWAKE_TIMEOUT_US      2000
`define CWAKE_TIMEOUT_CYC     (`CWAKE_TIMEOUT_US * 25)
`define CWAKE_CNT_W           20
`define CWAKE_MODE_RST        1'b1
`define CWAKE_RX_RST          1'b1
`endif

// ---- shared/cwake_pkg.sv ----
/*
  Types for the mode and wake detect block.
  Assumes cwake_params.svh is in the include path.
*/
package cwake_pkg;
  typedef enum logic [4:0] {
    CWAKE_IDLE  = 5'h01,
    CWAKE_DOM1  = 5'h02,
    CWAKE_REC1  = 5'h04,
    CWAKE_DOM2  = 5'h08,
    CWAKE_WOKEN = 5'h10
  } cwake_state_t;
endpackage

// ---- design/cwake_channel.sv ----
/*
  One channel: mode latch, bus driver, receive mux, wake detector.
  Assumes bus comparator outputs are synchronous to clk_sys_i.
*/
`timescale 1ns/1ns
`include "cwake_params.svh"
module cwake_channel #(
  parameter int unsigned FILTER_CYC  = `CWAKE_FILTER_CYC,
  parameter int unsigned TIMEOUT_CYC = `CWAKE_TIMEOUT_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic mode_select_i,
  input  wire logic transmit_input_i,
  input  wire logic bus_dom_normal_i,
  input  wire logic bus_dom_lp_i,
  output logic      standby_o,
  output logic      drive_dominant_n_o,
  output logic      bias_recessive_o,
  output logic      receive_output_o
);
  import cwake_pkg::*;

  typedef struct packed {
    logic                      standby;
    logic                      drv_n;
    logic                      bias;
    logic                      rx;
    logic                      lvl;
    logic [`CWAKE_CNT_W-1:0]   run;
    logic [`CWAKE_CNT_W-1:0]   tmo;
    cwake_state_t              st;
  } cwake_ch_t;

  cwake_ch_t s;
  cwake_ch_t next_s;
  logic      filt;

  // filtered once the level has held for more than FILTER_CYC cycles
  assign filt = (s.run == `CWAKE_CNT_W'(FILTER_CYC + 1));

  always_comb begin
    next_s = s;
    // R1 mode from pin
    next_s.standby = mode_select_i;
    if (!s.standby) begin
      // R2 normal driver
      next_s.drv_n = transmit_input_i;
      next_s.bias  = 1'b1;
      // R3 normal receive, R17 low is dominant
      next_s.rx    = !bus_dom_normal_i;
      next_s.st    = CWAKE_IDLE;
      next_s.run   = '0;
      next_s.tmo   = '0;
      next_s.lvl   = 1'b0;
    end else begin
      // R4 driver off, weak ground
      next_s.drv_n = 1'b1;
      next_s.bias  = 1'b0;
      // R5 R16 low-power receiver feeds monitor; R9 R20 run counter
      next_s.lvl = bus_dom_lp_i;
      if (bus_dom_lp_i != s.lvl)
        next_s.run = '0;
      else if (!filt)
        next_s.run = s.run + 1'b1;
      if (s.st != CWAKE_IDLE && s.st != CWAKE_WOKEN)
        next_s.tmo = s.tmo + 1'b1;
      // R10 R13 ordered pattern, other traffic ignored
      case (s.st)
        CWAKE_IDLE: if (filt && s.lvl) begin
          next_s.st  = CWAKE_DOM1;
          next_s.tmo = '0;
        end
        CWAKE_DOM1: if (filt && !s.lvl) next_s.st = CWAKE_REC1;
        CWAKE_REC1: if (filt && s.lvl)  next_s.st = CWAKE_DOM2;
        // R11 recognised at second recessive
        CWAKE_DOM2: if (filt && !s.lvl) next_s.st = CWAKE_WOKEN;
        CWAKE_WOKEN: ;
        default: next_s.st = CWAKE_IDLE;
      endcase
      // R14 R15 timeout drops all progress
      if (s.st != CWAKE_IDLE && s.st != CWAKE_WOKEN &&
          s.tmo >= `CWAKE_CNT_W'(TIMEOUT_CYC)) begin
        next_s.st  = CWAKE_IDLE;
        next_s.tmo = '0;
      end
      // R6 R12 held high until woken, then low on filtered dominant
      next_s.rx = !(s.st == CWAKE_WOKEN && filt && s.lvl);
      if (s.st == CWAKE_WOKEN && s.lvl && s.run != '0 && !s.rx)
        next_s.rx = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s         <= '0;
      // R18 standby by default
      s.standby <= `CWAKE_MODE_RST;
      s.drv_n   <= 1'b1;
      s.rx      <= `CWAKE_RX_RST;
      s.st      <= CWAKE_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign standby_o          = s.standby;
  assign drive_dominant_n_o = s.drv_n;
  assign bias_recessive_o   = s.bias;
  assign receive_output_o   = s.rx;

  // R4 no drive in standby
  chk_standby_no_drive: assert property (@(posedge clk_sys_i)  // R4
    disable iff (!rst_n_i) s.standby |=> s.drv_n)
    else $error("driver active in standby");
  // R4 bias off in standby
  chk_standby_no_bias: assert property (@(posedge clk_sys_i)  // R4
    disable iff (!rst_n_i) s.standby |=> !s.bias)
    else $error("bus bias active in standby");
  // R6 no wake low before recognition
  chk_rx_high_early: assert property (@(posedge clk_sys_i)  // R6
    disable iff (!rst_n_i) (s.standby && $past(s.standby) &&
      $past(s.st) != CWAKE_WOKEN) |-> s.rx)
    else $error("receive low before wake");
  // R2 normal tx follows
  chk_tx_follows: assert property (@(posedge clk_sys_i)  // R2
    disable iff (!rst_n_i) (!s.standby && !mode_select_i) |=>
      s.drv_n == $past(transmit_input_i))
    else $error("driver not following transmit");
  // R3 normal receive mirrors bus
  chk_normal_rx_mirror: assert property (@(posedge clk_sys_i)  // R3
    disable iff (!rst_n_i) !s.standby |=>
      s.rx == !$past(bus_dom_normal_i))
    else $error("receive not mirroring bus");
  // R13 no progress without filtered level
  chk_short_no_advance: assert property (@(posedge clk_sys_i)  // R13
    disable iff (!rst_n_i) !filt |=>
      (s.st == $past(s.st) || s.st == CWAKE_IDLE))
    else $error("wake progress without filtered level");
  // R14 timeout bound
  chk_timeout_bound: assert property (@(posedge clk_sys_i)  // R14
    disable iff (!rst_n_i) s.tmo <= `CWAKE_CNT_W'(TIMEOUT_CYC))
    else $error("timeout counter overran");
  // R14 R15 timeout drops progress
  chk_timeout_drop: assert property (@(posedge clk_sys_i)  // R14 R15
    disable iff (!rst_n_i) (s.st != CWAKE_IDLE && s.st != CWAKE_WOKEN &&
      s.tmo >= `CWAKE_CNT_W'(TIMEOUT_CYC)) |=>
      (s.st == CWAKE_IDLE && s.tmo == '0))
    else $error("timeout kept wake progress");
endmodule // cwake_channel

// ---- design/cwake_top.sv ----
/*
  Dual channel mode control and remote wake detection.
  Assumes bus comparators give dominant flags synchronous to clk_sys_i.
*/
`timescale 1ns/1ns
`include "cwake_params.svh"
module cwake_top (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] mode_select_i,
  input  wire logic [1:0] transmit_input_i,
  input  wire logic [1:0] bus_dom_normal_i,
  input  wire logic [1:0] bus_dom_lp_i,
  output logic      [1:0] standby_o,
  output logic      [1:0] drive_dominant_n_o,
  output logic      [1:0] bias_recessive_o,
  output logic      [1:0] receive_output_o
);
  import cwake_pkg::*;

  // R7 R19 one independent instance per channel
  for (genvar c = 0; c < 2; c++) begin : g_ch
    cwake_channel u_ch (
      .clk_sys_i          (clk_sys_i),
      .rst_n_i            (rst_n_i),
      .mode_select_i      (mode_select_i[c]),
      .transmit_input_i   (transmit_input_i[c]),
      .bus_dom_normal_i   (bus_dom_normal_i[c]),
      .bus_dom_lp_i       (bus_dom_lp_i[c]),
      .standby_o          (standby_o[c]),
      .drive_dominant_n_o (drive_dominant_n_o[c]),
      .bias_recessive_o   (bias_recessive_o[c]),
      .receive_output_o   (receive_output_o[c])
    );
  end
endmodule // cwake_top

// ---- sim/cwake_bus_model.sv ----
/*
  Bus model: both local drivers and a remote node on a wired bus.
  Assumes remote activity is given per channel by the bench.
*/
`timescale 1ns/1ns
module cwake_bus_model (
  input  wire logic [1:0] drive_dominant_n_i,
  input  wire logic [1:0] remote_dom_i,
  output logic      [1:0] bus_dom_normal_o,
  output logic      [1:0] bus_dom_lp_o
);
  assign bus_dom_normal_o = ~drive_dominant_n_i | remote_dom_i;
  assign bus_dom_lp_o     = bus_dom_normal_o;
endmodule // cwake_bus_model

// ---- sim/tb_can_channel_mode_and_wake_detect.sv ----
/*
  Testbench for cwake_top with the bus model.
  Assumes default filter and timeout counts of the design.
*/
`timescale 1ns/1ns
module tb_can_channel_mode_and_wake_detect;
  logic       clk_sys_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic [1:0] mode, tx, rem, bn, bl, sb, dn, bias, rx;
  logic [7:0] lfsr = 8'h4B;
  int         n_errors = 0;
  int         check_count = 0;
  int         cyc = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  cwake_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .mode_select_i(mode), .transmit_input_i(tx),
    .bus_dom_normal_i(bn), .bus_dom_lp_i(bl), .standby_o(sb),
    .drive_dominant_n_o(dn), .bias_recessive_o(bias),
    .receive_output_o(rx));
  cwake_bus_model bus (.drive_dominant_n_i(dn), .remote_dom_i(rem),
    .bus_dom_normal_o(bn), .bus_dom_lp_o(bl));
  function automatic logic [7:0] next_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // rx low while own driver or remote node is dominant
  function automatic logic [1:0] exp_rx(input logic [1:0] t, r);
    return t & ~r;
  endfunction
  task chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task run(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task pat(input int d, input logic [1:0] m);
    rem = m;
    run(d);
    rem = 2'h0;
    run(d);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ceiling above the long timeout wait
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    mode = 2'h3; tx = 2'h3; rem = 2'h0;
    run(6);
    rst_n_i = 1'b1;
    chk("standby", 2'h3, sb);
    chk("bias", 2'h0, bias);
    mode = 2'h0;
    run(4);
    chk("standby", 2'h0, sb);
    chk("bias", 2'h3, bias);
    repeat (40) begin
      lfsr = next_rand(lfsr);
      tx = lfsr[1:0];
      rem = lfsr[3:2] & {2{lfsr[4]}};
      run(4);
      chk("drive", tx, dn);
      chk("rx", exp_rx(tx, rem), rx);
    end
    // first channel normal and dominant, second in standby
    mode = 2'h2; tx = 2'h0; rem = 2'h0;
    run(4);
    chk("standby", 2'h2, sb);
    chk("drive", 2'h2, dn);
    chk("bias", 2'h1, bias);
    chk("rx", 2'h2, rx);
    mode = 2'h3;
    run(4);
    chk("standby", 2'h3, sb);
    chk("drive", 2'h3, dn);
    chk("bias", 2'h0, bias);
    repeat (4) pat(10, 2'h1);
    chk("rx", 2'h3, rx);
    pat(30, 2'h1);
    // short traffic between steps must keep progress
    pat(10, 2'h1);
    pat(30, 2'h1);
    chk("rx", 2'h3, rx);
    rem = 2'h1;
    run(30);
    chk("rx", 2'h2, rx);
    // reset in mid-run forgets the recognised wake
    rst_n_i = 1'b0;
    run(2);
    chk("standby", 2'h3, sb);
    chk("rx", 2'h3, rx);
    rst_n_i = 1'b1;
    run(30);
    chk("rx", 2'h3, rx);
    // host answers the fall by going back to normal
    rem = 2'h0;
    mode = 2'h0;
    run(4);
    mode = 2'h3;
    run(4);
    pat(30, 2'h2);
    pat(30, 2'h2);
    rem = 2'h2;
    run(30);
    chk("rx", 2'h1, rx);
    pat(30, 2'h1);
    run(50100);
    pat(30, 2'h1);
    rem = 2'h1;
    run(30);
    chk("rx", 2'h3, rx);
    close_out;
  end
endmodule // tb_can_channel_mode_and_wake_detect
